// File: enc_defines.vh
// Constants shared by the encoder node design files.
`ifndef ENC_DEFINES_VH
`define ENC_DEFINES_VH
// Register byte addresses.
`define ENC_A_MODE    8'h00
`define ENC_A_CYCLE   8'h04
`define ENC_A_SYNCN   8'h08
`define ENC_A_PRESET  8'h0C
`define ENC_A_CTRL    8'h10
`define ENC_A_STEPS   8'h14
`define ENC_A_REVS    8'h18
`define ENC_A_POS     8'h1C
`define ENC_A_STATUS  8'h20
`define ENC_A_SWITCH  8'h24
`define ENC_A_PROFILE 8'h28
// Operating modes.
`define ENC_M_POLL    2'h0
`define ENC_M_CYCLIC  2'h1
`define ENC_M_SYNC    2'h2
`define ENC_M_ACYC    2'h3
// Reset values.
`define ENC_RST_MODE  2'h0
`define ENC_RST_CYCLE 16'h0064
`define ENC_RST_SYNCN 8'h01
`define ENC_RST_STEPS 16'h1000
`define ENC_RST_REVS  16'h1000
`define ENC_RST_NODE  7'h01
`define ENC_RST_BAUD  3'h2
`define ENC_PROFILE   32'h00000002
// Status bit positions.
`define ENC_ST_POS    0
`define ENC_ST_PARAM  1
`define ENC_ST_BATT   2
// Message identifier bases.
`define ENC_ID_PDO1   11'h180
`define ENC_ID_PDO2   11'h280
`define ENC_ID_SDO    11'h580
// Raw count layout: low bits are the fraction of one revolution.
`define ENC_FRAC_W    12
// Timing: one millisecond, and the clock period.
`define ENC_MS_NS     1000000
`define ENC_CLK_NS    10
`define ENC_CYC_PER_MS (`ENC_MS_NS / `ENC_CLK_NS)
`endif

// File: enc_modu.v
// Sequential remainder unit, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module enc_modu (
  // Clock and reset.
  input  wire        clk_in,
  input  wire        rstn_in,
  // Operands and start.
  input  wire        start_in,
  input  wire [31:0] num_in,
  input  wire [31:0] den_in,
  // Result.
  output reg         done_out,
  output reg  [31:0] rem_out
);
  reg  [31:0] quo_reg;
  reg  [5:0]  cnt_reg;
  reg         busy_reg;
  wire [32:0] trial = {rem_out, quo_reg[31]};

  // Restoring division; the divisor is never zero because the range
  // registers refuse zero.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rem_out  <= 32'h00000000;
      quo_reg  <= 32'h00000000;
      cnt_reg  <= 6'h00;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem_out  <= 32'h00000000;
        quo_reg  <= num_in;
        cnt_reg  <= 6'h20;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (trial >= {1'b0, den_in})
          rem_out <= trial[31:0] - den_in;
        else
          rem_out <= trial[31:0];
        quo_reg <= {quo_reg[30:0], 1'b0};
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // enc_modu
`default_nettype wire

// File: enc_cyctmr.v
// Millisecond cycle timer for self-timed position transmission.
`include "enc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module enc_cyctmr #(
  parameter [31:0] CYC_PER_MS = `ENC_CYC_PER_MS
) (
  // Clock and reset.
  input  wire        clk_in,
  input  wire        rstn_in,
  // Control.
  input  wire        run_in,
  input  wire [15:0] period_ms_in,
  // Expiry pulse.
  output reg         fire_out
);
  reg [31:0] pre_reg;
  reg [15:0] ms_reg;

  // Prescaler makes a millisecond tick; the second counter counts ticks.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_reg  <= 32'h00000000;
      ms_reg   <= 16'h0000;
      fire_out <= 1'b0;
    end else begin
      fire_out <= 1'b0;
      if (!run_in) begin
        pre_reg <= 32'h00000000;
        ms_reg  <= 16'h0000;
      end else if (pre_reg == CYC_PER_MS - 32'h00000001) begin
        pre_reg <= 32'h00000000;
        if (ms_reg + 16'h0001 >= period_ms_in) begin
          ms_reg   <= 16'h0000;
          fire_out <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 16'h0001;
        end
      end else begin
        pre_reg <= pre_reg + 32'h00000001;
      end
    end
  end
endmodule // enc_cyctmr
`default_nettype wire

// File: enc_node.v
// Position node: transmission modes, preset, scaling, switches, faults.
// What this block does
// - Polled mode answers each service data request with current position.
// - Cyclic mode sends position by itself, repeatedly, without requests.
// - Cyclic period is a whole number of milliseconds, 1 to 65535.
// - Sync mode sends position in answer to master sync telegrams.
// - Send only after the configured count of syncs, then count again.
// - Writing a preset makes the reported position equal that value.
// - Offset from a preset is kept and added to every later report.
// - Direction bit selects rising or falling code for one rotation sense.
// - Steps per turn and turn count configurable; position scaled.
// - Report position fault, parameter fault and low backup cell voltage.
// - Acts as profile class 2 node on extended-frame capable bus.
// - Defaults are fifty kilobit per second and node number one.
// - Three switches give bit rate code, switch 1 most significant.
// - Node address read from decimal rotary switches, used as identity.
//
// The register offsets and the strobed register port are this design's own decisions.
`include "enc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module enc_node #(
  parameter [31:0] CYC_PER_MS = `ENC_CYC_PER_MS
) (
  // Clock and reset.
  input  wire        core_clk_in,
  input  wire        rstn_in,
  // Register port.
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  // Sensor count, same clock: turns above, fraction below.
  input  wire [23:0] raw_count_in,
  // Fault pins from the sensor head.
  input  wire        pos_fault_in,
  input  wire        batt_low_in,
  // Switch pins.
  input  wire [2:0]  baud_sw_in,
  input  wire [3:0]  node_tens_sw_in,
  input  wire [3:0]  node_ones_sw_in,
  // Received messages from the bus controller.
  input  wire        sdo_req_in,
  input  wire        sync_in,
  // Transmit request to the bus controller.
  output reg         tx_req_out,
  output reg  [10:0] tx_id_out,
  output reg  [31:0] tx_data_out,
  input  wire        tx_ack_in,
  // Switch results and the combined fault flag.
  output reg  [2:0]  baud_code_out,
  output reg  [6:0]  node_id_out,
  output reg         fault_out
);
  // ********************************************************
  // Reset release and pin synchronisers
  // ********************************************************
  reg       rst_s1_reg;
  reg       rst_s2_reg;
  wire      rstn = rst_s2_reg;

  // Reset enters asynchronously but is released on the clock.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  reg [12:0] pin_s1_reg;
  reg [12:0] pin_s2_reg;

  // Two stages for every asynchronous pin; only the second is read.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 13'h0000;
      pin_s2_reg <= 13'h0000;
    end else begin
      pin_s1_reg <= {pos_fault_in, batt_low_in, baud_sw_in,
                     node_tens_sw_in, node_ones_sw_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire       pfault_s = pin_s2_reg[12];
  wire       batt_s   = pin_s2_reg[11];
  wire [2:0] baud_s   = pin_s2_reg[10:8];
  wire [3:0] tens_s   = pin_s2_reg[7:4];
  wire [3:0] ones_s   = pin_s2_reg[3:0];

  // ********************************************************
  // Helper functions
  // ********************************************************
  // Sum of two values below the range, folded back into the range.
  function [31:0] mod_add;
    input [31:0] a;
    input [31:0] b;
    input [31:0] rng;
    reg   [32:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, rng})
        s = s - {1'b0, rng};
      mod_add = s[31:0];
    end
  endfunction

  // Difference of two values below the range, folded into the range.
  function [31:0] mod_sub;
    input [31:0] a;
    input [31:0] b;
    input [31:0] rng;
    begin
      if (a >= b)
        mod_sub = a - b;
      else
        mod_sub = mod_add(a, rng - b, rng);
    end
  endfunction

  // ********************************************************
  // Configuration registers
  // ********************************************************
  reg [1:0]  mode_reg;
  reg [15:0] cycle_reg;
  reg [7:0]  syncn_reg;
  reg [31:0] preset_reg;
  reg        dir_down_reg;
  reg [15:0] steps_reg;
  reg [15:0] revs_reg;
  reg        preset_pend_reg;
  reg        perr_reg;
  reg        preset_take;

  wire [31:0] range = steps_reg * revs_reg;
  wire [31:0] new_range_s = wdata_in[15:0] * revs_reg;
  wire [31:0] new_range_r = steps_reg * wdata_in[15:0];
  wire        wr_bad = wr_in &&
    (((addr_in == `ENC_A_CYCLE) && (wdata_in[15:0] == 16'h0000)) ||
     ((addr_in == `ENC_A_SYNCN) && (wdata_in[7:0] == 8'h00)) ||
     ((addr_in == `ENC_A_STEPS) &&
      ((wdata_in[15:0] == 16'h0000) || (preset_reg >= new_range_s))) ||
     ((addr_in == `ENC_A_REVS) &&
      ((wdata_in[15:0] == 16'h0000) || (preset_reg >= new_range_r))) ||
     ((addr_in == `ENC_A_PRESET) && (wdata_in >= range)));

  // Software writes; a bad value is refused and raises the fault.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      mode_reg        <= `ENC_RST_MODE;
      cycle_reg       <= `ENC_RST_CYCLE;
      syncn_reg       <= `ENC_RST_SYNCN;
      preset_reg      <= 32'h00000000;
      dir_down_reg    <= 1'b0;
      steps_reg       <= `ENC_RST_STEPS;
      revs_reg        <= `ENC_RST_REVS;
      preset_pend_reg <= 1'b0;
      perr_reg        <= 1'b0;
    end else begin
      if (preset_take)
        preset_pend_reg <= 1'b0;
      if (wr_in && (addr_in == `ENC_A_STATUS) && wdata_in[`ENC_ST_PARAM])
        perr_reg <= 1'b0;
      if (wr_bad)
        perr_reg <= 1'b1;
      if (wr_in && !wr_bad) begin
        case (addr_in)
          `ENC_A_MODE:  mode_reg <= wdata_in[1:0];
          `ENC_A_CYCLE: cycle_reg <= wdata_in[15:0];
          `ENC_A_SYNCN: syncn_reg <= wdata_in[7:0];
          `ENC_A_PRESET: begin
            preset_reg      <= wdata_in;
            preset_pend_reg <= 1'b1;
          end
          `ENC_A_CTRL:  dir_down_reg <= wdata_in[0];
          `ENC_A_STEPS: steps_reg <= wdata_in[15:0];
          `ENC_A_REVS:  revs_reg <= wdata_in[15:0];
          default: ;
        endcase
      end
    end
  end

  // ********************************************************
  // Position pipeline
  // ********************************************************
  localparam [1:0] PS_START = 2'h0;
  localparam [1:0] PS_WAIT  = 2'h1;
  localparam [1:0] PS_DONE  = 2'h2;

  reg  [1:0]  ps_reg;
  reg  [31:0] offset_reg;
  reg  [31:0] pos_reg;
  wire        mod_done;
  wire [31:0] mod_rem;

  wire [11:0] turns = raw_count_in[23:`ENC_FRAC_W];
  wire [11:0] frac  = raw_count_in[`ENC_FRAC_W-1:0];
  wire [27:0] frac_x = frac * steps_reg;
  wire [31:0] scaled = turns * steps_reg + {16'h0000, frac_x[27:12]};

  wire [31:0] dir_pos = !dir_down_reg ? mod_rem :
                        (mod_rem == 32'h00000000) ? 32'h00000000 :
                        range - mod_rem;

  enc_modu u_modu (
    .clk_in   (core_clk_in),
    .rstn_in  (rstn),
    .start_in (ps_reg == PS_START),
    .num_in   (scaled),
    .den_in   (range),
    .done_out (mod_done),
    .rem_out  (mod_rem)
  );

  always @* begin
    preset_take = (ps_reg == PS_DONE) && preset_pend_reg;
  end

  // The count is re-reduced every 35 cycles; a report lags its sample by 34 cycles.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      ps_reg     <= PS_START;
      offset_reg <= 32'h00000000;
      pos_reg    <= 32'h00000000;
    end else begin
      case (ps_reg)
        PS_START: ps_reg <= PS_WAIT;
        PS_WAIT:  if (mod_done) ps_reg <= PS_DONE;
        PS_DONE: begin
          ps_reg <= PS_START;
          if (preset_pend_reg) begin
            offset_reg <= mod_sub(preset_reg, dir_pos, range);
            pos_reg    <= preset_reg;
          end else begin
            pos_reg <= mod_add(dir_pos, offset_reg, range);
          end
        end
        default: ps_reg <= PS_START;
      endcase
    end
  end

  // ********************************************************
  // Transmission triggers
  // ********************************************************
  wire       cyc_fire;
  reg  [7:0] sync_cnt_reg;
  reg        pend_sdo_reg;
  reg        pend_pdo_reg;
  reg        pdo_sync_reg;
  reg        acyc_arm_reg;

  enc_cyctmr #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tmr (
    .clk_in       (core_clk_in),
    .rstn_in      (rstn),
    .run_in       (mode_reg == `ENC_M_CYCLIC),
    .period_ms_in (cycle_reg),
    .fire_out     (cyc_fire)
  );

  wire sync_hit = sync_in && (sync_cnt_reg + 8'h01 >= syncn_reg);
  wire tx_done  = tx_req_out && tx_ack_in;
  wire load_sdo = !tx_req_out && pend_sdo_reg;
  wire load_pdo = !tx_req_out && !pend_sdo_reg && pend_pdo_reg;

  // A trigger in the cycle its pending flag is taken still stands.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      sync_cnt_reg <= 8'h00;
      pend_sdo_reg <= 1'b0;
      pend_pdo_reg <= 1'b0;
      pdo_sync_reg <= 1'b0;
      acyc_arm_reg <= 1'b0;
    end else begin
      if (load_sdo)
        pend_sdo_reg <= 1'b0;
      if (load_pdo)
        pend_pdo_reg <= 1'b0;
      if (sdo_req_in)
        pend_sdo_reg <= 1'b1;
      if (cyc_fire) begin
        pend_pdo_reg <= 1'b1;
        pdo_sync_reg <= 1'b0;
      end
      if (mode_reg != `ENC_M_SYNC)
        sync_cnt_reg <= 8'h00;
      else if (sync_in)
        sync_cnt_reg <= sync_hit ? 8'h00 : sync_cnt_reg + 8'h01;
      if ((mode_reg == `ENC_M_SYNC) && sync_hit) begin
        pend_pdo_reg <= 1'b1;
        pdo_sync_reg <= 1'b1;
      end
      // Acyclic mode: a request arms one send at the next sync.
      if (mode_reg != `ENC_M_ACYC)
        acyc_arm_reg <= 1'b0;
      else if (sdo_req_in)
        acyc_arm_reg <= 1'b1;
      else if (sync_in && acyc_arm_reg) begin
        acyc_arm_reg <= 1'b0;
        pend_pdo_reg <= 1'b1;
        pdo_sync_reg <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Transmit port and switch decode
  // ********************************************************
  reg [6:0] node_dec;

  always @* begin
    node_dec = 7'h00;
    if ((tens_s < 4'hA) && (ones_s < 4'hA))
      node_dec = tens_s * 7'h0A + {3'h0, ones_s};
  end

  // Requests stand until acknowledged; the service answer goes first.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      tx_req_out    <= 1'b0;
      tx_id_out     <= 11'h000;
      tx_data_out   <= 32'h00000000;
      baud_code_out <= `ENC_RST_BAUD;
      node_id_out   <= `ENC_RST_NODE;
      fault_out     <= 1'b0;
    end else begin
      baud_code_out <= baud_s;
      if ((node_dec == 7'h00) || (node_dec > 7'h7F))
        node_id_out <= `ENC_RST_NODE;
      else
        node_id_out <= node_dec;
      fault_out <= pfault_s | batt_s | perr_reg;
      if (tx_done)
        tx_req_out <= 1'b0;
      if (load_sdo) begin
        tx_req_out  <= 1'b1;
        tx_id_out   <= `ENC_ID_SDO + {4'h0, node_id_out};
        tx_data_out <= pos_reg;
      end else if (load_pdo) begin
        tx_req_out  <= 1'b1;
        tx_id_out   <= (pdo_sync_reg ? `ENC_ID_PDO2 : `ENC_ID_PDO1) +
                       {4'h0, node_id_out};
        tx_data_out <= pos_reg;
      end
    end
  end

  // ********************************************************
  // Register read port
  // ********************************************************
  // Read data stand in the cycle after the strobe only.
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      rdata_out <= 32'h00000000;
    end else if (!rd_in) begin
      rdata_out <= 32'h00000000;
    end else begin
      case (addr_in)
        `ENC_A_MODE:   rdata_out <= {30'h0, mode_reg};
        `ENC_A_CYCLE:  rdata_out <= {16'h0000, cycle_reg};
        `ENC_A_SYNCN:  rdata_out <= {24'h000000, syncn_reg};
        `ENC_A_PRESET: rdata_out <= preset_reg;
        `ENC_A_CTRL:   rdata_out <= {31'h0, dir_down_reg};
        `ENC_A_STEPS:  rdata_out <= {16'h0000, steps_reg};
        `ENC_A_REVS:   rdata_out <= {16'h0000, revs_reg};
        `ENC_A_POS:    rdata_out <= pos_reg;
        `ENC_A_STATUS: rdata_out <= {29'h0, batt_s, perr_reg, pfault_s};
        `ENC_A_SWITCH: rdata_out <= {21'h0, baud_code_out, 1'b0,
                                     node_id_out};
        `ENC_A_PROFILE: rdata_out <= `ENC_PROFILE;
        default:       rdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule // enc_node
`default_nettype wire

// File: enc_node_chk.sv
// Port checker for the encoder node, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module enc_node_chk (
  input wire        core_clk_in,
  input wire        rstn_in,
  input wire [7:0]  addr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  input wire        pos_fault_in,
  input wire [2:0]  baud_sw_in,
  input wire [3:0]  node_tens_sw_in,
  input wire [3:0]  node_ones_sw_in,
  input wire        sdo_req_in,
  input wire        tx_req_out,
  input wire [10:0] tx_id_out,
  input wire [31:0] tx_data_out,
  input wire        tx_ack_in,
  input wire [2:0]  baud_code_out,
  input wire [6:0]  node_id_out,
  input wire        fault_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Decimal node number; bad settings fall back to node one.
  wire [7:0] nd_sum = node_tens_sw_in * 8'd10 + node_ones_sw_in;
  wire       nd_ok  = (node_tens_sw_in < 4'hA) && (node_ones_sw_in < 4'hA)
                      && (nd_sum != 8'h0) && (nd_sum < 8'h80);
  wire [6:0] nd_exp = nd_ok ? nd_sum[6:0] : 7'h01;
  // A frame waits for the controller, then is taken.
  sequence s_wait; tx_req_out && !tx_ack_in; endsequence
  sequence s_take; tx_req_out && tx_ack_in; endsequence
  a_profile_read: assert property (
    rd_in && addr_in == 8'h28 |=> rdata_out == 32'h2)
    else $error("profile read wrong");
  a_rdata_quiet: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0) else $error("rdata not idle");
  a_req_hold: assert property (s_wait |=> tx_req_out
    && $stable(tx_id_out) && $stable(tx_data_out)) else $error("req moved");
  a_req_drop: assert property (s_take |=> !tx_req_out)
    else $error("req not dropped");
  a_sdo_answer: assert property (sdo_req_in && !tx_req_out
    |-> ##[2:60] (tx_req_out && tx_id_out[10:7] == 4'hB))
    else $error("no answer to request");
  a_tx_id_kind: assert property (tx_req_out |->
    tx_id_out[6:0] == node_id_out && tx_id_out[10:7] inside {4'h3, 4'h5,
    4'hB}) else $error("bad identifier");
  a_baud_map: assert property (
    $stable(baud_sw_in) [*8] |-> baud_code_out == baud_sw_in)
    else $error("bit rate code wrong");
  a_node_map: assert property (
    $stable({node_tens_sw_in, node_ones_sw_in}) [*8]
    |-> node_id_out == nd_exp) else $error("node number wrong");
  a_fault_seen: assert property (pos_fault_in [*8] |-> fault_out)
    else $error("fault not shown");
endmodule // enc_node_chk
bind enc_node enc_node_chk chk (.core_clk_in(core_clk_in),
  .rstn_in(rstn_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pos_fault_in(pos_fault_in),
  .baud_sw_in(baud_sw_in), .node_tens_sw_in(node_tens_sw_in),
  .node_ones_sw_in(node_ones_sw_in), .sdo_req_in(sdo_req_in),
  .tx_req_out(tx_req_out), .tx_id_out(tx_id_out),
  .tx_data_out(tx_data_out), .tx_ack_in(tx_ack_in),
  .baud_code_out(baud_code_out), .node_id_out(node_id_out),
  .fault_out(fault_out));
`default_nettype wire

// File: enc_can_host.sv
// Behavioural bus controller facing the node's message ports.
`timescale 1ns/1ps
`default_nettype none
module enc_can_host (
  // Clock, frames from the node and the acceptance delay.
  input  wire logic        clk_in,
  input  wire logic        tx_req_in,
  input  wire logic [10:0] tx_id_in,
  input  wire logic [31:0] tx_data_in,
  input  wire logic [3:0]  ack_dly_in,
  // Answers and received telegrams.
  output var  logic        tx_ack_out,
  output var  logic        sdo_req_out,
  output var  logic        sync_out
);
  int          frames;
  int          wait_cnt;
  logic [10:0] last_id;
  logic [31:0] last_data;
  initial begin
    tx_ack_out = 1'b0;
    sdo_req_out = 1'b0;
    sync_out = 1'b0;
    frames = 0;
    wait_cnt = 0;
  end
  // frame acceptance: a slow ack keeps the request waiting.
  always @(posedge clk_in) begin
    tx_ack_out <= 1'b0;
    if (tx_req_in && !tx_ack_out) begin
      if (wait_cnt >= ack_dly_in) begin
        tx_ack_out <= 1'b1;
        frames <= frames + 1;
        last_id <= tx_id_in;
        last_data <= tx_data_in;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
  // one-cycle request or sync telegram from the master.
  task pulse(input bit is_sync);
    @(posedge clk_in);
    if (is_sync) sync_out <= 1'b1;
    else sdo_req_out <= 1'b1;
    @(posedge clk_in);
    sync_out <= 1'b0;
    sdo_req_out <= 1'b0;
  endtask
endmodule // enc_can_host
`default_nettype wire

// File: tb.sv
// Self-checking bench for the encoder node.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, wr, rd, pf, bl, req, ack, sdo, syn;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, txd;
  logic [23:0] raw;
  logic [2:0]  baud, bcode;
  logic [3:0]  tens, ones, dly;
  logic [10:0] txid;
  logic [6:0]  nid;
  logic        flt;
  int fails, num_checks, n0;
  // Register table reset rows and the values they must read.
  logic [7:0]  ta [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
                          8'h20, 8'h28, 8'h30};
  logic [31:0] te [9] = '{32'h0, 32'h64, 32'h1, 32'h0, 32'h1000,
                          32'h1000, 32'h0, 32'h2, 32'h0};
  enc_node #(.CYC_PER_MS(32'd10)) dut (.core_clk_in(clk), .rstn_in(rstn),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .raw_count_in(raw), .pos_fault_in(pf),
    .batt_low_in(bl), .baud_sw_in(baud), .node_tens_sw_in(tens),
    .node_ones_sw_in(ones), .sdo_req_in(sdo), .sync_in(syn),
    .tx_req_out(req), .tx_id_out(txid), .tx_data_out(txd),
    .tx_ack_in(ack), .baud_code_out(bcode), .node_id_out(nid),
    .fault_out(flt));
  enc_can_host m (.clk_in(clk), .tx_req_in(req), .tx_id_in(txid),
    .tx_data_in(txd), .ack_dly_in(dly), .tx_ack_out(ack),
    .sdo_req_out(sdo), .sync_out(syn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task nf;
    int n;
    n = m.frames;
    for (int i = 0; i < 200 && m.frames == n; i++) @(posedge clk);
    chk(m.frames != n, 1);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about 1100 cycles.
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    {rstn, wr, rd, pf, bl, addr, wdata} = '0;
    baud = 3'h2;
    tens = 4'h2;
    ones = 4'h3;
    dly = 4'h8;
    raw = {12'd3, 12'h800};
    repeat (2) @(posedge clk);
    #1 chk(bcode, 3'h2);
    chk(nid, 7'h01);
    @(posedge clk) rstn <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 9; i++) rdc(ta[i], te[i]);
    chk(nid, 7'd23);
    rdc(8'h24, 32'h217);
    for (int b = 0; b < 8; b++) begin
      baud <= b[2:0];
      repeat (8) @(posedge clk);
      chk(bcode, b[2:0]);
    end
    tens <= 4'hA;
    repeat (8) @(posedge clk);
    chk(nid, 7'h01);
    tens <= 4'h4;
    ones <= 4'h5;
    repeat (8) @(posedge clk);
    chk(nid, 7'd45);
    tens <= 4'h0;
    ones <= 4'h0;
    repeat (8) @(posedge clk);
    chk(nid, 7'h01);
    ones <= 4'h3;
    tens <= 4'h2;
    repeat (80) @(posedge clk);
    rdc(8'h1C, 32'd14336);
    m.pulse(1'b0);
    nf();
    chk(m.last_id, 11'h597);
    chk(m.last_data, 32'd14336);
    wr_reg(8'h14, 32'd100);
    wr_reg(8'h18, 32'd10);
    repeat (80) @(posedge clk);
    rdc(8'h1C, 32'd350);
    wr_reg(8'h10, 32'h1);
    repeat (80) @(posedge clk);
    rdc(8'h1C, 32'd650);
    wr_reg(8'h0C, 32'd100);
    repeat (80) @(posedge clk);
    rdc(8'h1C, 32'd100);
    raw <= {12'd5, 12'h800};
    repeat (80) @(posedge clk);
    rdc(8'h1C, 32'd900);
    pf <= 1'b1;
    repeat (8) @(posedge clk);
    chk(flt, 1'b1);
    rdc(8'h20, 32'h1);
    pf <= 1'b0;
    bl <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(8'h20, 32'h4);
    bl <= 1'b0;
    wr_reg(8'h04, 32'h0);
    rdc(8'h04, 32'h64);
    rdc(8'h20, 32'h2);
    wr_reg(8'h20, 32'h2);
    repeat (4) @(posedge clk);
    rdc(8'h20, 32'h0);
    dly <= 4'h0;
    wr_reg(8'h04, 32'h2);
    n0 = m.frames;
    wr_reg(8'h00, 32'h1);
    repeat (400) @(posedge clk);
    wr_reg(8'h00, 32'h0);
    chk(m.last_id, 11'h197);
    chk((m.frames - n0 >= 17) && (m.frames - n0 <= 21), 1);
    wr_reg(8'h08, 32'h3);
    wr_reg(8'h00, 32'h2);
    repeat (20) @(posedge clk);
    n0 = m.frames;
    m.pulse(1'b1);
    m.pulse(1'b1);
    repeat (20) @(posedge clk);
    chk(m.frames - n0, 0);
    m.pulse(1'b1);
    nf();
    chk(m.last_id, 11'h297);
    n0 = m.frames;
    m.pulse(1'b1);
    m.pulse(1'b1);
    repeat (20) @(posedge clk);
    chk(m.frames - n0, 0);
    // Acyclic mode: a request is answered and arms one send at next sync.
    dly <= 4'h3;
    wr_reg(8'h00, 32'h3);
    m.pulse(1'b0);
    nf();
    chk(m.last_id, 11'h597);
    m.pulse(1'b1);
    nf();
    chk(m.last_id, 11'h297);
    // Reset in mid-run: outputs fall back and settings return to defaults.
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(bcode, 3'h2);
    chk(nid, 7'h01);
    chk(req, 1'b0);
    @(posedge clk) rstn <= 1'b1;
    repeat (10) @(posedge clk);
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h1);
    chk(bcode, 3'h7);
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
